// ### core/ric_ctrl.sv
// interrupt front end: priority, masks, enable, restart and acknowledge
// assumes the core drives sample_window_i, halt_i, rd_phase_i on sys_clk_i
// What this block does
// - trap ranks first, vectors to 24H, needs rising edge then high level
// - edge-latched restart ranks second and vectors to 3CH
// - level restarts vector to 34H and 2CH, sampled like the general request
// - pending requests resolve by fixed priority, general request last
// - program counter is pushed before the jump to the vector
// - maskable restart needs global enable set and its mask clear
// - trap is taken whatever the enable and masks
// - edge restart sets a latch that clears itself when serviced
// - set-mask word and reset also clear the edge restart latch
// - the edge latch captures pulses even while masked
// - priority ignores which handler is running
// - trap needs a low then high again before it is seen again
// - taking any interrupt clears the global enable
// - trap saves the enable; first read-mask returns it, later ones live
// - after other interrupts the read-mask shows the live enable
// - read-mask samples serial in; set-mask drives serial out
// - all interrupt pins are synchronised to the clock
// - requests are sampled only in the sample window, hold or halt
// - general request inhibits the pc increment and strobes acknowledge
// - reset clears the global enable and the hold acknowledge
// - read-mask puts serial in level on bit 7
`timescale 1ns/1ps
module ric_ctrl (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic trap_i,
  input wire logic rst75_i,
  input wire logic rst65_i,
  input wire logic rst55_i,
  input wire logic general_request_i,
  input wire logic serial_in_line_i,
  input wire logic hold_request_i,
  input wire logic sample_window_i,
  input wire logic halt_i,
  input wire logic rd_phase_i,
  input wire logic [7:0] ack_data_i,
  output logic general_acknowledge_strobe_o,
  output logic pc_inc_inhibit_o,
  output logic push_pc_o,
  output logic jump_o,
  output logic [7:0] vector_o,
  output logic [7:0] ack_instr_o,
  output logic serial_out_line_o,
  output logic hold_acknowledge_o
);

  typedef struct packed {
    ric_pkg::ric_st_t st;
    ric_pkg::ric_src_t src;
    logic ie;
    logic ie_saved;
    logic trap_rdm;
    logic trap_arm;
    logic r75;
    logic [2:0] mask;
    logic sout;
    logic hold_ack;
    logic ack;
    logic rd_seen;
    logic [7:0] rdata;
    logic [7:0] vector;
    logic [7:0] instr;
  } ric_state_t;

  ric_state_t q_r;
  ric_state_t q_nxt;

  logic [ric_pkg::PIN_N-1:0] lvl;
  logic [ric_pkg::PIN_N-1:0] rise;
  logic sample;
  logic [4:0] req;
  ric_pkg::ric_src_t pick;
  logic take;
  logic acc;
  logic commit;
  logic sim_wr;
  logic sim_r75_clr;
  logic [7:0] rdm_word;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  ric_pin_if pins ();

  assign pins.raw = {hold_request_i, serial_in_line_i, general_request_i,
                     rst55_i, rst65_i, rst75_i, trap_i};

  ric_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i (rst_n_i),
    .pins (pins)
  );

  assign lvl = pins.lvl;
  assign rise = pins.rise;

  // ****************************************************************
  // request qualification
  // ****************************************************************
  function automatic ric_pkg::ric_src_t ric_pick(input logic [4:0] r);
    if (r[0]) begin
      return ric_pkg::SRC_TRAP;
    end else if (r[1]) begin
      return ric_pkg::SRC_R75;
    end else if (r[2]) begin
      return ric_pkg::SRC_R65;
    end else if (r[3]) begin
      return ric_pkg::SRC_R55;
    end else if (r[4]) begin
      return ric_pkg::SRC_GEN;
    end
    return ric_pkg::SRC_NONE;
  endfunction : ric_pick

  // sampled in the next-to-last cycle, in halt and in hold
  assign sample = sample_window_i | halt_i | q_r.hold_ack;

  // trap ignores enable and masks
  assign req[0] = q_r.trap_arm & lvl[ric_pkg::PIN_TRAP];
  assign req[1] = q_r.r75 & q_r.ie & ~q_r.mask[2];
  assign req[2] = lvl[ric_pkg::PIN_R65] & q_r.ie & ~q_r.mask[1];
  assign req[3] = lvl[ric_pkg::PIN_R55] & q_r.ie & ~q_r.mask[0];
  assign req[4] = lvl[ric_pkg::PIN_GEN] & q_r.ie;

  // no notion of the running handler's rank
  assign pick = ric_pick(req);
  assign take = (q_r.st == ric_pkg::ST_IDLE) & sample &
                (pick != ric_pkg::SRC_NONE);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  assign acc = avs_read_i | avs_write_i;
  assign commit = acc & q_r.ack;
  assign sim_wr = commit & avs_write_i & avs_byteenable_i[0] &
                  (avs_address_i == ric_pkg::OFF_SIM);
  assign sim_r75_clr = sim_wr & avs_writedata_i[ric_pkg::SIM_R75CLR];

  // saved enable on the first read after a trap, live afterwards
  assign rdm_word = {lvl[ric_pkg::PIN_SIN], q_r.r75, lvl[ric_pkg::PIN_R65],
                     lvl[ric_pkg::PIN_R55],
                     q_r.trap_rdm ? q_r.ie_saved : q_r.ie,
                     q_r.mask};

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    q_nxt = q_r;
    q_nxt.ack = acc & ~q_r.ack;
    q_nxt.hold_ack = lvl[ric_pkg::PIN_HOLD];

    // read data is latched in the wait cycle
    if (acc & ~q_r.ack) begin
      q_nxt.rdata = 8'h00;
      if (avs_read_i) begin
        unique case (avs_address_i)
          ric_pkg::OFF_SIM: q_nxt.rdata = {q_r.sout, 4'h0, q_r.mask};
          ric_pkg::OFF_RDM: q_nxt.rdata = rdm_word;
          ric_pkg::OFF_IE: q_nxt.rdata = {1'b0, q_r.hold_ack, q_r.st, 3'h0, q_r.ie};
          ric_pkg::OFF_ACK: q_nxt.rdata = q_r.instr;
          default: q_nxt.rdata = 8'h00;
        endcase
      end
    end

    // set-mask word
    if (sim_wr) begin
      if (avs_writedata_i[ric_pkg::SIM_MSE]) begin
        q_nxt.mask = avs_writedata_i[2:0];
      end
      if (avs_writedata_i[ric_pkg::SIM_SOUTE]) begin
        q_nxt.sout = avs_writedata_i[ric_pkg::SIM_SOUT];
      end
    end
    if (commit & avs_write_i & avs_byteenable_i[0] &
        (avs_address_i == ric_pkg::OFF_IE)) begin
      q_nxt.ie = avs_writedata_i[ric_pkg::IE_BIT];
    end
    // the read-mask access consumes the saved trap state
    if (commit & avs_read_i & (avs_address_i == ric_pkg::OFF_RDM)) begin
      q_nxt.trap_rdm = 1'b0;
    end

    // trap arms on a rise and disarms when the line drops
    q_nxt.trap_arm = lvl[ric_pkg::PIN_TRAP] &
                     (q_r.trap_arm | rise[ric_pkg::PIN_TRAP]);

    // edge restart latch, set wins over every clear
    if (sim_r75_clr | (take & (pick == ric_pkg::SRC_R75))) begin
      q_nxt.r75 = 1'b0;
    end
    if (rise[ric_pkg::PIN_R75]) begin
      q_nxt.r75 = 1'b1;
    end

    unique case (q_r.st)
      ric_pkg::ST_IDLE: begin
        if (take) begin
          q_nxt.src = pick;
          q_nxt.ie = 1'b0;
          q_nxt.trap_rdm = 1'b0;
          q_nxt.st = ric_pkg::ST_PUSH;
          case (pick)
            ric_pkg::SRC_TRAP: begin
              q_nxt.vector = ric_pkg::VEC_TRAP;
              q_nxt.ie_saved = q_r.ie;
              q_nxt.trap_rdm = 1'b1;
              q_nxt.trap_arm = rise[ric_pkg::PIN_TRAP];
            end
            ric_pkg::SRC_R75: begin
              q_nxt.vector = ric_pkg::VEC_R75;
            end
            ric_pkg::SRC_R65: begin
              q_nxt.vector = ric_pkg::VEC_R65;
            end
            ric_pkg::SRC_R55: begin
              q_nxt.vector = ric_pkg::VEC_R55;
            end
            default: begin
              q_nxt.st = ric_pkg::ST_ACK;
              q_nxt.rd_seen = 1'b0;
            end
          endcase
        end
      end
      ric_pkg::ST_PUSH: begin
        q_nxt.st = ric_pkg::ST_JUMP;
      end
      ric_pkg::ST_JUMP: begin
        q_nxt.st = ric_pkg::ST_IDLE;
      end
      ric_pkg::ST_ACK: begin
        // capture the inserted instruction while the strobe is high
        if (rd_phase_i) begin
          q_nxt.rd_seen = 1'b1;
          q_nxt.instr = ack_data_i;
        end else if (q_r.rd_seen) begin
          q_nxt.st = ric_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= '0;
      q_r.mask <= ric_pkg::MASK_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign avs_readdata_o = {24'h000000, q_r.rdata};
  assign avs_waitrequest_o = acc & ~q_r.ack;
  assign general_acknowledge_strobe_o = (q_r.st == ric_pkg::ST_ACK) &
                                        rd_phase_i;
  assign pc_inc_inhibit_o = (q_r.st == ric_pkg::ST_ACK);
  assign push_pc_o = (q_r.st == ric_pkg::ST_PUSH);
  assign jump_o = (q_r.st == ric_pkg::ST_JUMP);
  assign vector_o = q_r.vector;
  assign ack_instr_o = q_r.instr;
  assign serial_out_line_o = q_r.sout;
  assign hold_acknowledge_o = q_r.hold_ack;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking ric_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_trap_first;
    (q_r.st == ric_pkg::ST_IDLE) && sample && req[0]
      |=> (q_r.st == ric_pkg::ST_PUSH) && (q_r.src == ric_pkg::SRC_TRAP);
  endproperty
  a_trap_first: assert property (p_trap_first)
    else $error("trap not taken first");

  property p_r75_over_levels;
    (q_r.st == ric_pkg::ST_IDLE) && sample && !req[0] && req[1]
      |=> (q_r.src == ric_pkg::SRC_R75) ##1 jump_o && (vector_o == 8'h3C);
  endproperty
  a_r75_over_levels: assert property (p_r75_over_levels)
    else $error("edge restart lost its rank or vector");

  property p_push_then_jump;
    push_pc_o |=> jump_o ##1 !jump_o && !push_pc_o;
  endproperty
  a_push_then_jump: assert property (p_push_then_jump)
    else $error("pc push not followed by one jump");

  property p_mask_gate;
    $rose(push_pc_o) && (q_r.src == ric_pkg::SRC_R65)
      |-> $past(q_r.ie) && !$past(q_r.mask[1]);
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("masked restart was taken");

  property p_r75_capture;
    rise[ric_pkg::PIN_R75] ##1 !(sim_r75_clr || (take && (pick == ric_pkg::SRC_R75)))
      |-> q_r.r75 ##1 q_r.r75;
  endproperty
  a_r75_capture: assert property (p_r75_capture)
    else $error("edge restart pulse not held");

  property p_trap_once;
    take && (pick == ric_pkg::SRC_TRAP) && !rise[ric_pkg::PIN_TRAP]
      |=> !q_r.trap_arm;
  endproperty
  a_trap_once: assert property (p_trap_once)
    else $error("trap still armed after service");

  property p_enable_cleared;
    take |=> !q_r.ie throughout (push_pc_o or pc_inc_inhibit_o);
  endproperty
  a_enable_cleared: assert property (p_enable_cleared)
    else $error("enable not cleared on interrupt");

  property p_hold_sampling;
    (q_r.st == ric_pkg::ST_IDLE) && !sample |=> (q_r.st == ric_pkg::ST_IDLE);
  endproperty
  a_hold_sampling: assert property (p_hold_sampling)
    else $error("request taken outside the sample window");

  property p_gen_ack;
    take && (pick == ric_pkg::SRC_GEN)
      |=> pc_inc_inhibit_o && !push_pc_o && (rd_phase_i == general_acknowledge_strobe_o);
  endproperty
  a_gen_ack: assert property (p_gen_ack)
    else $error("general request not acknowledged");

  property p_rdm_saved;
    q_r.ack && avs_read_i && (avs_address_i == ric_pkg::OFF_RDM) &&
      $past(q_r.trap_rdm) && q_r.trap_rdm
      |-> (avs_readdata_o[ric_pkg::RDM_IE] == q_r.ie_saved) ##1 !q_r.trap_rdm;
  endproperty
  a_rdm_saved: assert property (p_rdm_saved)
    else $error("saved enable not reported once");

  property p_wait_one;
    acc && !q_r.ack |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus answer late");

endmodule : ric_ctrl

// ### pkg/ric_pkg.sv
// shared constants and types of the restart interrupt control block
// assumes a 10 MHz sys_clk_i and an Avalon-MM register bus with byte addresses
package ric_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] OFF_SIM = 4'h0;
  localparam logic [3:0] OFF_RDM = 4'h4;
  localparam logic [3:0] OFF_IE = 4'h8;
  localparam logic [3:0] OFF_ACK = 4'hC;

  // set-mask word fields
  localparam int SIM_MSE = 3;
  localparam int SIM_R75CLR = 4;
  localparam int SIM_SOUTE = 6;
  localparam int SIM_SOUT = 7;

  // read-mask word fields
  localparam int RDM_IE = 3;
  localparam int RDM_PEND = 4;
  localparam int RDM_SIN = 7;

  // enable word fields
  localparam int IE_BIT = 0;

  // values after reset
  localparam logic [2:0] MASK_RST = 3'h7;

  // ****************************************************************
  // restart vectors
  // ****************************************************************
  localparam logic [7:0] VEC_TRAP = 8'h24;
  localparam logic [7:0] VEC_R75 = 8'h3C;
  localparam logic [7:0] VEC_R65 = 8'h34;
  localparam logic [7:0] VEC_R55 = 8'h2C;

  // ****************************************************************
  // pin positions in the synchronised input vector
  // ****************************************************************
  localparam int PIN_N = 7;
  localparam int PIN_TRAP = 0;
  localparam int PIN_R75 = 1;
  localparam int PIN_R65 = 2;
  localparam int PIN_R55 = 3;
  localparam int PIN_GEN = 4;
  localparam int PIN_SIN = 5;
  localparam int PIN_HOLD = 6;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_JUMP = 2'b10,
    ST_ACK = 2'b11
  } ric_st_t;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_TRAP = 3'b001,
    SRC_R75 = 3'b010,
    SRC_R65 = 3'b011,
    SRC_R55 = 3'b100,
    SRC_GEN = 3'b101
  } ric_src_t;

endpackage : ric_pkg

// ### pkg/ric_pin_if.sv
// carrier between the pin synchroniser and the interrupt control logic
// assumes all raw pins are asynchronous to sys_clk_i
`timescale 1ns/1ps
interface ric_pin_if;
  logic [ric_pkg::PIN_N-1:0] raw;
  logic [ric_pkg::PIN_N-1:0] lvl;
  logic [ric_pkg::PIN_N-1:0] rise;
  modport sync (input raw, output lvl, output rise);
  modport user (output raw, input lvl, input rise);
endinterface : ric_pin_if

// ### core/ric_sync.sv
// two-flop synchroniser with rising edge detect for the interrupt pins
// assumes the pins are asynchronous; a third stage feeds the edge detect
`timescale 1ns/1ps
module ric_sync (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  ric_pin_if.sync pins
);

  typedef struct packed {
    logic [ric_pkg::PIN_N-1:0] s1;
    logic [ric_pkg::PIN_N-1:0] s2;
    logic [ric_pkg::PIN_N-1:0] s3;
  } ric_sync_t;

  ric_sync_t q_r;
  ric_sync_t q_nxt;

  // ****************************************************************
  // synchroniser stages
  // ****************************************************************
  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = pins.raw;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign pins.lvl = q_r.s2;
  assign pins.rise = q_r.s2 & ~q_r.s3;

endmodule : ric_sync

// ### sim/ric_periph.sv
// peripheral side model: interrupt sources and the supplier of the acknowledge instruction
// assumes the bench asks for requests on req_i and the block answers on push/vector/strobe
`timescale 1ns/1ps
module ric_periph (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] req_i,
  input wire logic [7:0] instr_i,
  input wire logic push_pc_i,
  input wire logic [7:0] vector_i,
  input wire logic strobe_i,
  output logic trap_o,
  output logic rst75_o,
  output logic rst65_o,
  output logic rst55_o,
  output logic gen_o,
  output logic [7:0] ack_data_o
);
  // ****************************************************************
  // request lines and acknowledge data
  // ****************************************************************
  logic [7:0] idle_r;
  logic trap_hold_r;

  // trap rises with the request and is held until its own push
  assign trap_o = req_i[0] | trap_hold_r;
  assign rst75_o = req_i[1];
  assign rst65_o = req_i[2];
  assign rst55_o = req_i[3];
  // bus not driven outside the strobe: show the inverse of the last value
  assign ack_data_o = strobe_i ? instr_i : idle_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trap_hold_r <= 1'h0;
      gen_o <= 1'h0;
      idle_r <= 8'h00;
    end else begin
      idle_r <= ~ack_data_o;
      if (req_i[0]) begin
        trap_hold_r <= 1'h1;
      end else if (push_pc_i && vector_i == ric_pkg::VEC_TRAP) begin
        trap_hold_r <= 1'h0;
      end
      if (req_i[4]) begin
        gen_o <= 1'h1;
      end else if (strobe_i) begin
        gen_o <= 1'h0;
      end
    end
  end
endmodule : ric_periph

// ### sim/test_restart_interrupt_control.sv
// self-checking bench of the restart interrupt control block
// assumes a 10 MHz clock and the one-wait-cycle Avalon-MM slave of the block
`timescale 1ns/1ps
module test_restart_interrupt_control;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic sys_clk_i, rst_n_i, avs_read_i, avs_write_i, serial_in_line_i, hold_request_i;
  logic sample_window_i, halt_i, rd_phase_i;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic avs_waitrequest_o, trap_i, rst75_i, rst65_i, rst55_i, general_request_i;
  logic general_acknowledge_strobe_o, pc_inc_inhibit_o, push_pc_o, jump_o;
  logic serial_out_line_o, hold_acknowledge_o;
  logic [7:0] ack_data_i, vector_o, ack_instr_o;
  logic [4:0] req;
  int error_cnt, n_compared;
  localparam logic [7:0] INSTR = 8'hE7;

  ric_ctrl ric_ctrl_i (.sys_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .trap_i,
    .rst75_i, .rst65_i, .rst55_i, .general_request_i, .serial_in_line_i, .hold_request_i,
    .sample_window_i, .halt_i, .rd_phase_i, .ack_data_i, .general_acknowledge_strobe_o,
    .pc_inc_inhibit_o, .push_pc_o, .jump_o, .vector_o, .ack_instr_o, .serial_out_line_o,
    .hold_acknowledge_o);

  ric_periph ric_periph_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req),
    .instr_i(INSTR), .push_pc_i(push_pc_o), .vector_i(vector_o),
    .strobe_i(general_acknowledge_strobe_o), .trap_o(trap_i), .rst75_o(rst75_i),
    .rst65_o(rst65_i), .rst55_o(rst55_i), .gen_o(general_request_i), .ack_data_o(ack_data_i));

  initial begin
    sys_clk_i = 1'h0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    int n;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'h0 && n < 40);
    if (avs_waitrequest_o !== 1'h0) begin
      error_cnt++;
      conclude();
    end
    rd = avs_readdata_o[7:0];
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(1'h1, a, d, x);
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] x;
    bus(1'h0, a, 8'h00, x);
    chk(x, exp);
  endtask : rdchk

  // waits for the push pulse (sel 0) or the acknowledge state (sel 1)
  task automatic wait_on(input int sel);
    int n;
    n = 0;
    while ((sel == 0 ? push_pc_o : pc_inc_inhibit_o) !== 1'h1 && n < 60) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 60) begin
      error_cnt++;
      conclude();
    end
  endtask : wait_on

  task automatic take(input logic [7:0] vec);
    wait_on(0);
    chk(vector_o, vec);
    @(negedge sys_clk_i);
    chk({7'h00, jump_o}, 8'h01);
    @(posedge sys_clk_i);
  endtask : take

  task automatic pulse(input logic [4:0] r);
    @(posedge sys_clk_i);
    req <= req | r;
    @(posedge sys_clk_i);
    req <= req & ~r;
  endtask : pulse

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst_n_i = 1'h0;
    {avs_read_i, avs_write_i, serial_in_line_i, hold_request_i} = 4'h0;
    {sample_window_i, halt_i, rd_phase_i} = 3'h0;
    avs_address_i = 4'h0;
    avs_byteenable_i = 4'hF;
    avs_writedata_i = 32'h00000000;
    req = 5'h00;
    error_cnt = 0;
    n_compared = 0;
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    rdchk(4'h4, 8'h07);
    wr(4'h8, 8'h01);
    hold_request_i <= 1'h1;
    repeat (5) @(negedge sys_clk_i);
    rdchk(4'h8, 8'h41);
    @(posedge sys_clk_i);
    rst_n_i <= 1'h0;
    @(negedge sys_clk_i);
    chk({7'h00, hold_acknowledge_o}, 8'h00);
    @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    hold_request_i <= 1'h0;
    rdchk(4'h8, 8'h00);
    pulse(5'h02);
    repeat (4) @(posedge sys_clk_i);
    rdchk(4'h4, 8'h47);
    wr(4'h0, 8'h18);
    rdchk(4'h4, 8'h00);
    pulse(5'h02);
    @(posedge sys_clk_i);
    req <= 5'h0C;
    repeat (4) @(posedge sys_clk_i);
    rdchk(4'h4, 8'h70);
    wr(4'h8, 8'h01);
    repeat (6) @(negedge sys_clk_i);
    chk({7'h00, push_pc_o}, 8'h00);
    @(posedge sys_clk_i);
    halt_i <= 1'h1;
    take(ric_pkg::VEC_R75);
    halt_i <= 1'h0;
    sample_window_i <= 1'h1;
    rdchk(4'h4, 8'h30);
    wr(4'h8, 8'h01);
    take(ric_pkg::VEC_R65);
    req <= 5'h08;
    wr(4'h8, 8'h01);
    take(ric_pkg::VEC_R55);
    req <= 5'h00;
    wr(4'h0, 8'hC0);
    serial_in_line_i <= 1'h1;
    @(negedge sys_clk_i);
    chk({7'h00, serial_out_line_o}, 8'h01);
    repeat (4) @(posedge sys_clk_i);
    rdchk(4'h4, 8'h80);
    rdchk(4'h0, 8'h80);
    serial_in_line_i <= 1'h0;
    wr(4'h8, 8'h01);
    pulse(5'h01);
    take(ric_pkg::VEC_TRAP);
    rdchk(4'h4, 8'h08);
    rdchk(4'h4, 8'h00);
    wr(4'h0, 8'h0F);
    pulse(5'h01);
    take(ric_pkg::VEC_TRAP);
    wr(4'h0, 8'h08);
    wr(4'h8, 8'h01);
    pulse(5'h03);
    take(ric_pkg::VEC_TRAP);
    repeat (8) @(negedge sys_clk_i);
    chk({7'h00, push_pc_o}, 8'h00);
    wr(4'h8, 8'h01);
    take(ric_pkg::VEC_R75);
    wr(4'h8, 8'h01);
    pulse(5'h10);
    wait_on(1);
    chk({7'h00, general_acknowledge_strobe_o}, 8'h00);
    @(posedge sys_clk_i);
    rd_phase_i <= 1'h1;
    @(negedge sys_clk_i);
    chk({6'h00, general_acknowledge_strobe_o, pc_inc_inhibit_o}, 8'h03);
    @(posedge sys_clk_i);
    rd_phase_i <= 1'h0;
    repeat (3) @(posedge sys_clk_i);
    chk(ack_instr_o, INSTR);
    rdchk(4'hC, INSTR);
    rdchk(4'h4, 8'h00);
    conclude();
  end
endmodule : test_restart_interrupt_control
